// ---- rtl/iface_stats_message_codec.v ----
`timescale 1ns/100ps
`default_nettype none
`include "stats_codec_defs.vh"
module iface_stats_message_codec (
   input wire ref_clk,
   input wire rst_b,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   input wire rx_sop,
   input wire [15:0] rx_opcode,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_eop,
   output reg fld_req_q,
   output reg fld_kind_q,
   output reg [15:0] fld_index_q,
   output reg [4:0] fld_sel_q,
   input wire fld_ack,
   input wire fld_ok,
   input wire [63:0] fld_value,
   output reg [15:0] tx_opcode_q,
   output reg tx_valid_q,
   output reg [7:0] tx_data_q,
   output reg tx_first_q,
   output reg tx_last_q,
   input wire tx_ready,
   output reg bond_req_q
);
   localparam [1:0] P_IDLE = 2'd0;
   localparam [1:0] P_CNT = 2'd1;
   localparam [1:0] P_HI = 2'd2;
   localparam [1:0] P_LO = 2'd3;
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_PROBE = 3'd1;
   localparam [2:0] S_PWAIT = 3'd2;
   localparam [2:0] S_CNT = 3'd3;
   localparam [2:0] S_FREQ = 3'd4;
   localparam [2:0] S_FWAIT = 3'd5;
   localparam [2:0] S_SHIFT = 3'd6;

   // Byte width of each field, in record order
   function [3:0] fwidth;
      input kind;
      input [4:0] f;
      begin
         if (kind == `KIND_SQ) begin
            case (f)
               5'h00: fwidth = 4'h2;
               5'h01: fwidth = 4'h1;
               5'h02, 5'h03, 5'h04: fwidth = 4'h8;
               5'h05: fwidth = 4'h4;
               default: fwidth = 4'h1;
            endcase
         end else begin
            case (f)
               5'h00, 5'h01: fwidth = 4'h2;
               5'h02: fwidth = 4'h4;
               5'h03, 5'h04: fwidth = 4'h1;
               5'h05: fwidth = 4'h4;
               5'h06, 5'h07, 5'h08, 5'h09: fwidth = 4'h8;
               5'h0a, 5'h0b, 5'h0c: fwidth = 4'h4;
               5'h0d, 5'h0e, 5'h0f, 5'h10: fwidth = 4'h8;
               5'h11, 5'h12: fwidth = 4'h4;
               5'h13, 5'h14, 5'h15: fwidth = 4'h1;
               default: fwidth = 4'h4;
            endcase
         end
      end
   endfunction

   // Turns the raw source value into its wire code
   function [63:0] fencode;
      input kind;
      input [4:0] f;
      input [63:0] v;
      begin
         fencode = v;
         if (kind == `KIND_SQ) begin
            if (f == 5'h01)
               fencode = {56'h0, (v[0] ? `ENC_TRUE : `ENC_FALSE)};
            else if (f == 5'h06 && v > {56'h0, `MICRO_MAX})
               fencode = {56'h0, `MICRO_MAX};
         end else begin
            if (f == 5'h03 && (v[7:0] == 8'h00 || v[7:0] > `ADMIN_MAX || v[63:8] != 56'h0))
               fencode = {56'h0, `ADMIN_DOWN};
            else if (f == 5'h04 && (v[7:0] == 8'h00 || v[7:0] > `OPER_MAX || v[63:8] != 56'h0))
               fencode = {56'h0, `OPER_UNKNOWN};
            else if (f == 5'h13 || f == 5'h14 || f == 5'h15)
               fencode = {56'h0, (v[0] ? `ENC_TRUE : `ENC_FALSE)};
         end
      end
   endfunction

   reg [15:0] idx_mem [0:255];
   reg ok_mem [0:255];

   reg [31:0] ctrl_q;
   reg [31:0] drop_q;
   reg [31:0] sent_q;
   reg [1:0] pst_q;
   reg [15:0] rop_q;
   reg [7:0] want_q;
   reg [7:0] got_q;
   reg [7:0] hi_q;
   reg rx_act_q;
   reg [2:0] st_q;
   reg kind_q;
   reg [7:0] num_q;
   reg [7:0] rec_q;
   reg [7:0] okc_q;
   reg [7:0] rem_q;
   reg [4:0] fld_q;
   reg [3:0] bcnt_q;
   reg [63:0] sh_q;

   wire busy = (st_q != S_IDLE);
   wire enable = ctrl_q[`CTRL_EN_BIT];
   wire [4:0] last_fld = (kind_q == `KIND_SQ) ? `SQ_LAST_FLD : `ST_LAST_FLD;
   // A count byte must have arrived first; want_q is stale until then
   wire msg_ok = rx_act_q && (pst_q == P_HI) && (got_q == want_q);
   wire is_list = (rop_q == `OP_SQ_REQ) || (rop_q == `OP_ST_REQ);
   wire start = rx_eop && msg_ok && is_list && !busy;
   wire bond = rx_eop && rx_act_q && (rop_q == `OP_BOND_REQ);
   wire drop = rx_eop && rx_act_q && !start && !bond;
   wire out_free = !tx_valid_q || tx_ready;
   wire [63:0] enc_val = fencode(kind_q, fld_q, fld_value);
   wire [3:0] w_cur = fwidth(kind_q, fld_q);

   // Register port; read data stand in the following cycle only
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_q <= `CTRL_RESET;
         reg_rdata_q <= 32'h0;
      end else begin
         if (reg_wr && reg_addr == `REG_CTRL)
            ctrl_q <= {31'h0, reg_wdata[`CTRL_EN_BIT]};
         reg_rdata_q <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `REG_CTRL: reg_rdata_q <= ctrl_q;
               `REG_STATUS: reg_rdata_q <= {16'h0, okc_q, 5'h0, st_q};
               `REG_DROP: reg_rdata_q <= drop_q;
               `REG_SENT: reg_rdata_q <= sent_q;
               default: reg_rdata_q <= 32'h0;
            endcase
         end
      end
   end

   // Counters clear on write; a same-cycle event still counts
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         drop_q <= 32'h0;
         sent_q <= 32'h0;
      end else begin
         if (drop)
            drop_q <= (reg_wr && reg_addr == `REG_DROP) ? 32'h1 : drop_q + 32'h1;
         else if (reg_wr && reg_addr == `REG_DROP)
            drop_q <= 32'h0;
         if (st_q == S_CNT && out_free)
            sent_q <= (reg_wr && reg_addr == `REG_SENT) ? 32'h1 : sent_q + 32'h1;
         else if (reg_wr && reg_addr == `REG_SENT)
            sent_q <= 32'h0;
      end
   end

   // Request parser: count byte then two-byte indices, high byte first
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         pst_q <= P_IDLE;
         rop_q <= 16'h0;
         want_q <= 8'h0;
         got_q <= 8'h0;
         hi_q <= 8'h0;
         rx_act_q <= 1'b0;
         bond_req_q <= 1'b0;
      end else begin
         bond_req_q <= bond;
         if (rx_sop && enable) begin
            rx_act_q <= 1'b1;
            rop_q <= rx_opcode;
            pst_q <= P_CNT;
            got_q <= 8'h0;
         end else if (rx_valid && rx_act_q && !busy) begin
            // Request bytes are discarded while a response is being built
            case (pst_q)
               P_CNT: begin
                  want_q <= rx_data;
                  pst_q <= P_HI;
               end
               P_HI: begin
                  if (got_q != want_q) begin
                     hi_q <= rx_data;
                     pst_q <= P_LO;
                  end
               end
               P_LO: begin
                  idx_mem[got_q] <= {hi_q, rx_data};
                  got_q <= got_q + 8'h1;
                  pst_q <= P_HI;
               end
               default: pst_q <= P_IDLE;
            endcase
         end
         if (rx_eop && !(rx_sop && enable)) begin
            rx_act_q <= 1'b0;
            pst_q <= P_IDLE;
         end
      end
   end

   // Response builder: probe every index, then count, then records
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         kind_q <= `KIND_SQ;
         num_q <= 8'h0;
         rec_q <= 8'h0;
         okc_q <= 8'h0;
         rem_q <= 8'h0;
         fld_q <= 5'h0;
         bcnt_q <= 4'h0;
         sh_q <= 64'h0;
         fld_req_q <= 1'b0;
         fld_kind_q <= 1'b0;
         fld_index_q <= 16'h0;
         fld_sel_q <= 5'h0;
         tx_opcode_q <= 16'h0;
         tx_valid_q <= 1'b0;
         tx_data_q <= 8'h0;
         tx_first_q <= 1'b0;
         tx_last_q <= 1'b0;
      end else begin
         fld_req_q <= 1'b0;
         if (tx_valid_q && tx_ready)
            tx_valid_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (start) begin
                  kind_q <= (rop_q == `OP_ST_REQ) ? `KIND_ST : `KIND_SQ;
                  num_q <= want_q;
                  rec_q <= 8'h0;
                  okc_q <= 8'h0;
                  st_q <= (want_q == 8'h0) ? S_CNT : S_PROBE;
               end
            end
            S_PROBE: begin
               fld_req_q <= 1'b1;
               fld_kind_q <= kind_q;
               fld_index_q <= idx_mem[rec_q];
               fld_sel_q <= 5'h0;
               st_q <= S_PWAIT;
            end
            S_PWAIT: begin
               if (fld_ack) begin
                  ok_mem[rec_q] <= fld_ok;
                  okc_q <= okc_q + {7'h0, fld_ok};
                  rec_q <= rec_q + 8'h1;
                  st_q <= (rec_q + 8'h1 == num_q) ? S_CNT : S_PROBE;
               end
            end
            S_CNT: begin
               if (out_free) begin
                  tx_opcode_q <= (kind_q == `KIND_ST) ? `OP_ST_RSP : `OP_SQ_RSP;
                  tx_valid_q <= 1'b1;
                  tx_data_q <= okc_q;
                  tx_first_q <= 1'b1;
                  tx_last_q <= (okc_q == 8'h0);
                  rem_q <= okc_q;
                  rec_q <= 8'h0;
                  fld_q <= 5'h0;
                  st_q <= (okc_q == 8'h0) ? S_IDLE : S_FREQ;
               end
            end
            S_FREQ: begin
               if (!ok_mem[rec_q]) begin
                  rec_q <= rec_q + 8'h1;
               end else if (fld_q == 5'h0) begin
                  // Index comes from the request, not from the source
                  sh_q <= {idx_mem[rec_q], 48'h0};
                  bcnt_q <= 4'h2;
                  st_q <= S_SHIFT;
               end else begin
                  fld_req_q <= 1'b1;
                  fld_kind_q <= kind_q;
                  fld_index_q <= idx_mem[rec_q];
                  fld_sel_q <= fld_q;
                  st_q <= S_FWAIT;
               end
            end
            S_FWAIT: begin
               // A field that fails now is sent as zero; the count is already out
               if (fld_ack) begin
                  sh_q <= (fld_ok ? enc_val : 64'h0) << {(4'h8 - w_cur), 3'h0};
                  bcnt_q <= w_cur;
                  st_q <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               if (out_free) begin
                  tx_valid_q <= 1'b1;
                  tx_data_q <= sh_q[63:56];
                  tx_first_q <= 1'b0;
                  tx_last_q <= (bcnt_q == 4'h1) && (fld_q == last_fld) && (rem_q == 8'h1);
                  sh_q <= {sh_q[55:0], 8'h0};
                  bcnt_q <= bcnt_q - 4'h1;
                  if (bcnt_q == 4'h1) begin
                     if (fld_q == last_fld) begin
                        fld_q <= 5'h0;
                        rec_q <= rec_q + 8'h1;
                        rem_q <= rem_q - 8'h1;
                        st_q <= (rem_q == 8'h1) ? S_IDLE : S_FREQ;
                     end else begin
                        fld_q <= fld_q + 5'h1;
                        st_q <= S_FREQ;
                     end
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // iface_stats_message_codec
`default_nettype wire

// ---- shared/stats_codec_defs.vh ----
`ifndef STATS_CODEC_DEFS_VH
`define STATS_CODEC_DEFS_VH
// Message opcodes
`define OP_SQ_REQ 16'h0709
`define OP_SQ_RSP 16'h070a
`define OP_ST_REQ 16'h070b
`define OP_ST_RSP 16'h070c
`define OP_BOND_REQ 16'h070d
// Record kinds on the field source port
`define KIND_SQ 1'b0
`define KIND_ST 1'b1
// Last field number of each record kind
`define SQ_LAST_FLD 5'h06
`define ST_LAST_FLD 5'h16
// Field encodings
`define ENC_TRUE 8'h01
`define ENC_FALSE 8'h02
`define ADMIN_MAX 8'h03
`define OPER_MAX 8'h07
`define OPER_UNKNOWN 8'h04
`define ADMIN_DOWN 8'h02
`define MICRO_MAX 8'hff
// Register offsets and fields
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DROP 8'h08
`define REG_SENT 8'h0c
`define CTRL_EN_BIT 0
`define CTRL_RESET 32'h0000_0001
`endif

// ---- bench/stats_codec_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "stats_codec_defs.vh"
module stats_codec_properties (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic rx_eop,
   input wire logic tx_ready,
   input wire logic fld_req_q,
   input wire logic fld_kind_q,
   input wire logic [15:0] fld_index_q,
   input wire logic [4:0] fld_sel_q,
   input wire logic [15:0] tx_opcode_q,
   input wire logic tx_valid_q,
   input wire logic [7:0] tx_data_q,
   input wire logic tx_first_q,
   input wire logic tx_last_q,
   input wire logic bond_req_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   bond_pulse_a: assert property (bond_req_q |=> !bond_req_q)
      else $error("bond pulse too long");
   bond_cause_a: assert property (bond_req_q |-> $past(rx_eop))
      else $error("bond pulse without message end");
   tx_hold_a: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q)
      && $stable(tx_first_q) && $stable(tx_last_q))
      else $error("byte changed before accept");
   opcode_legal_a: assert property (tx_valid_q |-> tx_opcode_q == `OP_SQ_RSP
      || tx_opcode_q == `OP_ST_RSP)
      else $error("bad response opcode");
   opcode_steady_a: assert property (tx_valid_q && !tx_first_q |-> $stable(tx_opcode_q))
      else $error("opcode moved inside message");
   empty_count_a: assert property (tx_valid_q && tx_first_q && tx_last_q |-> tx_data_q == 8'h00)
      else $error("lone byte is not a zero count");
   fld_pulse_a: assert property (fld_req_q |=> !fld_req_q)
      else $error("field request too long");
   fld_stand_a: assert property (!fld_req_q |-> $stable(fld_index_q) && $stable(fld_sel_q)
      && $stable(fld_kind_q))
      else $error("field select moved without request");
   sel_range_a: assert property (fld_req_q |-> fld_sel_q <= (fld_kind_q ? `ST_LAST_FLD
      : `SQ_LAST_FLD))
      else $error("field number past record end");
   cover property (bond_req_q);
   cover property (tx_valid_q && tx_first_q && tx_last_q);
   cover property (tx_valid_q && tx_last_q && tx_opcode_q == `OP_ST_RSP);
endmodule // stats_codec_properties
bind iface_stats_message_codec stats_codec_properties chk (.ref_clk, .rst_b, .rx_eop,
   .tx_ready, .fld_req_q, .fld_kind_q, .fld_index_q, .fld_sel_q, .tx_opcode_q, .tx_valid_q,
   .tx_data_q, .tx_first_q, .tx_last_q, .bond_req_q);
`default_nettype wire

// ---- bench/stats_source_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module stats_source_model (
   input wire logic ref_clk,
   input wire logic fld_req_q,
   input wire logic fld_kind_q,
   input wire logic [15:0] fld_index_q,
   input wire logic [4:0] fld_sel_q,
   output logic fld_ack,
   output logic fld_ok,
   output logic [63:0] fld_value
);
   // Field widths in bytes, by field number; field 0 (the two-byte index) is held as 0 here
   function automatic int fw(input logic k, input logic [4:0] s);
      int sq[7] = '{0, 1, 8, 8, 8, 4, 1};
      int st[23] = '{0, 2, 4, 1, 1, 4, 8, 8, 8, 8, 4, 4, 4, 8, 8, 8, 8, 4, 4, 1, 1, 1, 4};
      return k ? st[s] : sq[s];
   endfunction
   function automatic logic fok(input logic [15:0] i);
      return i[2:0] != 3'd6;
   endfunction
   // Some second-pass fields fail, so the zero fill is exercised
   function automatic logic sel_ok(input logic [15:0] i, input logic [4:0] s);
      return fok(i) && !(s == 5'd5 && i[3]);
   endfunction
   // One-byte fields stay small so range clamps are hit without ambiguity
   function automatic logic [63:0] fval(input logic k, input logic [15:0] i, input logic [4:0] s);
      if (fw(k, s) > 1) return {i[7:0], 3'b000, s, 48'h9e37_79b9_7f4a};
      return (!k && s == 5'd6) ? {55'h0, i[4], i[7:0]} : {60'h0, i[3:0]};
   endfunction
   initial begin
      fld_ack = 1'b0;
      fld_ok = 1'b0;
      fld_value = '0;
   end
   // Latency varies from prompt to slow; value lines scramble once released
   always begin
      @(posedge ref_clk);
      if (fld_req_q === 1'b1) begin
         repeat ((fld_sel_q + fld_index_q[1:0]) % 4) @(posedge ref_clk);
         fld_ack <= 1'b1;
         fld_ok <= sel_ok(fld_index_q, fld_sel_q);
         fld_value <= fval(fld_kind_q, fld_index_q, fld_sel_q);
         @(posedge ref_clk);
         fld_ack <= 1'b0;
         fld_value <= ~fld_value;
      end
   end
endmodule // stats_source_model
`default_nettype wire

// ---- bench/iface_stats_message_codec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "stats_codec_defs.vh"
module iface_stats_message_codec_tb;
   logic ref_clk, rst_b, reg_wr, reg_rd, rx_sop, rx_valid, rx_eop, tx_ready, fld_req_q;
   logic fld_kind_q, fld_ack, fld_ok, tx_valid_q, tx_first_q, tx_last_q, bond_req_q;
   logic [7:0] reg_addr, rx_data, tx_data_q, nob[$];
   logic [31:0] reg_wdata, reg_rdata_q, seed, r;
   logic [15:0] rx_opcode, fld_index_q, tx_opcode_q;
   logic [4:0] fld_sel_q;
   logic [63:0] fld_value;
   logic [25:0] exp_q[$];
   int fails, cmp_count, bonds;
   iface_stats_message_codec dut (.*);
   stats_source_model src (.*);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic end_of_test;
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata_q;
      @(posedge ref_clk);
   endtask
   task automatic send(input logic [15:0] op, input logic [7:0] b[$]);
      rx_sop <= 1'b1;
      rx_opcode <= op;
      @(posedge ref_clk);
      rx_sop <= 1'b0;
      foreach (b[i]) begin
         rx_valid <= 1'b1;
         rx_data <= b[i];
         @(posedge ref_clk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_eop <= 1'b1;
      @(posedge ref_clk);
      rx_eop <= 1'b0;
      for (int t = 0; t < 5000 && exp_q.size() > 0; t++) @(posedge ref_clk);
      if (exp_q.size() > 0) begin
         fails++;
         $display("ERROR tx_drain expected 0 seen %0d", exp_q.size());
         end_of_test;
      end
      repeat (40) @(posedge ref_clk);
   endtask
   function automatic void put(input logic [15:0] op, input logic [63:0] v, input int w);
      for (int q = w - 1; q >= 0; q--) exp_q.push_back({op, 2'b00, v[8 * q +: 8]});
   endfunction
   function automatic logic [63:0] enc(input logic k, input logic [4:0] s, input logic [63:0] v);
      if (k ? (s >= 19 && s <= 21) : s == 1) return v[0] ? 1 : 2;
      if (!k && s == 6) return v > 255 ? 255 : v;
      if (k && s == 3) return (v >= 1 && v <= 3) ? v : 2;
      if (k && s == 4) return (v >= 1 && v <= 7) ? v : 4;
      return v;
   endfunction
   // Request of n indices, m of them actually sent; short lists get no answer
   task automatic request(input logic k, input int n, input int m, input bit live);
      logic [7:0] b[$];
      logic [15:0] ix[$];
      logic [15:0] op;
      int okn;
      op = k ? `OP_ST_RSP : `OP_SQ_RSP;
      b.push_back(n[7:0]);
      for (int j = 0; j < m; j++) begin
         ix.push_back(16'($random(seed)));
         b.push_back(ix[j][15:8]);
         b.push_back(ix[j][7:0]);
      end
      okn = 0;
      foreach (ix[j]) okn += src.fok(ix[j]);
      if (m == n && live) begin
         exp_q.push_back({op, 2'b10, okn[7:0]});
         foreach (ix[j]) if (src.fok(ix[j])) begin
            put(op, ix[j], 2);
            for (int s = 1; s <= (k ? 22 : 6); s++)
               put(op, src.sel_ok(ix[j], s) ? enc(k, s, src.fval(k, ix[j], s)) : 64'h0,
                  src.fw(k, s));
         end
         exp_q[exp_q.size() - 1][8] = 1'b1;
      end
      send(k ? `OP_ST_REQ : `OP_SQ_REQ, b);
   endtask
   always @(posedge ref_clk) begin
      tx_ready <= ($random(seed) & 3) != 0;
      if (bond_req_q === 1'b1) bonds++;
      if (rst_b && tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("ERROR tx_byte expected none seen %h", tx_data_q);
         end else
            check("tx_byte", exp_q.pop_front(), {tx_opcode_q, tx_first_q, tx_last_q, tx_data_q});
      end
   end
   initial begin
      seed = 32'h7d24e9de;
      {rst_b, reg_wr, reg_rd, rx_sop, rx_valid, rx_eop} = '0;
      {reg_addr, reg_wdata, rx_data, rx_opcode} = '0;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      rd(`REG_CTRL);
      check("ctrl", 32'h1, r);
      rd(`REG_STATUS);
      check("status", 32'h0, r);
      rd(8'h10);
      check("unmapped", 32'h0, r);
      for (int n = 0; n < 3; n++) begin
         request(0, n + 2, n + 2, 1);
         request(1, n + 1, n + 1, 1);
      end
      request(0, 0, 0, 1);
      send(`OP_BOND_REQ, nob);
      check("bond", 32'h1, bonds);
      send(`OP_SQ_REQ, nob);
      request(1, 2, 1, 1);
      send(16'h0705, nob);
      rd(`REG_DROP);
      check("drop", 32'h3, r);
      rd(`REG_SENT);
      check("sent", 32'h7, r);
      wr(`REG_DROP, 32'h0);
      rd(`REG_DROP);
      check("drop_clear", 32'h0, r);
      wr(`REG_CTRL, 32'h0);
      request(0, 1, 1, 0);
      rd(`REG_DROP);
      check("drop_off", 32'h0, r);
      wr(`REG_CTRL, 32'h1);
      request(1, 1, 1, 1);
      end_of_test;
   end
endmodule // iface_stats_message_codec_tb
`default_nettype wire
